// ### rtl/pmd_mgmt_pkg.sv
package pmd_mgmt_pkg;

  // ----------------------------------------
  // register offsets (device 1)
  // ----------------------------------------
  localparam logic [15:0] OFF_TX_OFF = 16'h0009;
  localparam logic [15:0] OFF_SIG_DET = 16'h000A;
  localparam logic [15:0] OFF_EXT_ABILITY = 16'h000B;
  localparam logic [15:0] OFF_PKG_ID_LOW = 16'h000E;
  localparam logic [15:0] OFF_PKG_ID_HIGH = 16'h000F;
  localparam logic [15:0] OFF_NV_CMD = 16'h8000;
  localparam logic [7:0] NV_PAGE = 8'h80;
  localparam logic [15:0] OFF_RX_ALARM_EN = 16'h9000;
  localparam logic [15:0] OFF_TX_ALARM_EN = 16'h9001;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam logic [15:0] RX_EN_MASK = 16'h0039;
  localparam logic [15:0] RX_EN_RESET = 16'h0039;
  localparam logic [15:0] TX_EN_MASK = 16'h02D9;
  localparam logic [15:0] TX_EN_RESET = 16'h02D9;
  localparam int CMD_DIR_BIT = 5;
  localparam logic [1:0] EXT_ONE_BYTE = 2'h2;
  localparam logic [1:0] EXT_ALL = 2'h3;
  localparam logic [4:0] DEV_PMA_PMD = 5'h01;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

  // ----------------------------------------
  // image layout
  // ----------------------------------------
  localparam logic [7:0] IMG_PKG_ID_FIRST = 8'h32;
  localparam logic [7:0] IMG_PKG_ID_LAST = 8'h35;
  localparam logic [7:0] IMG_CUST_FIRST = 8'h7E;
  localparam logic [7:0] IMG_CUST_LAST = 8'hAD;
  localparam int CUST_BYTES = 48;

  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam int PREAMBLE_BITS = 32;
  localparam logic [8:0] NV_BYTE_CYCLES = 9'h001;
  localparam logic [8:0] NV_ALL_CYCLES = 9'h100;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_DONE = 2'b01,
    NV_BUSY = 2'b10,
    NV_FAIL = 2'b11
  } nv_status_t;

  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_HEAD = 2'b01,
    MD_TURN = 2'b11,
    MD_DATA = 2'b10
  } mdio_state_t;

  // fixed image bytes
  function automatic logic [7:0] image_rom(input logic [7:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      8'h07: b = 8'h1E;
      8'h08: b = 8'h01;
      8'h0A: b = 8'h01;
      8'h0C: b = 8'h0B;
      8'h0D: b = 8'h77;
      8'h0E: b = 8'hA7;
      8'h0F: b = 8'h01;
      8'h12: b = 8'h02;
      8'h13: b = 8'h01;
      8'h14: b = 8'h01;
      8'h15: b = 8'h28;
      8'h16: b = 8'h48;
      8'h17: b = 8'h01;
      8'h23: b = 8'h1E;
      8'h24: b = 8'h01;
      8'h26: b = 8'h01;
      8'h27: b = 8'hFF;
      8'h28: b = 8'hB8;
      8'h77: b = 8'h10;
      8'h78: b = 8'h08;
      8'h79: b = 8'h08;
      8'h7A: b = 8'hC1;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

endpackage

// ### rtl/pmd_mgmt_nvr_alarm_regs.sv
`timescale 1ns/1ps
module pmd_mgmt_nvr_alarm_regs #(
  // arbitrary neutral identity value
  parameter logic [31:0] PKG_ID = 32'h0012_3450
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic [4:0] port_addr_in,
  // optics
  input wire logic signal_detect_in,
  output logic tx_off_out,
  // alarm sources
  input wire logic [15:0] rx_alarm_status_in,
  input wire logic [15:0] tx_alarm_status_in,
  input wire logic pcs_block_lock_in,
  input wire logic phy_xs_lane_align_in,
  // alarm outputs
  output logic rx_alarm_out,
  output logic tx_alarm_out,
  output logic link_status_alarm_out
);
  import pmd_mgmt_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] mdc_sync_reg;
  logic mdc_last_reg;
  logic [1:0] mdio_sync_reg;
  logic [1:0] sig_sync_reg;
  logic [4:0] prt_s1_reg;
  logic [4:0] prt_s2_reg;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mdc_sync_reg <= 2'h0;
      mdc_last_reg <= 1'b0;
      // idle-high pins reset high, so no false edge follows reset
      mdio_sync_reg <= 2'h3;
      sig_sync_reg <= 2'h3;
      prt_s1_reg <= 5'h00;
      prt_s2_reg <= 5'h00;
    end else begin
      mdc_sync_reg <= {mdc_sync_reg[0], mdc_in};
      mdc_last_reg <= mdc_sync_reg[1];
      mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
      sig_sync_reg <= {sig_sync_reg[0], signal_detect_in};
      prt_s1_reg <= port_addr_in;
      prt_s2_reg <= prt_s1_reg;
    end
  end

  wire mdc_rise = mdc_sync_reg[1] & ~mdc_last_reg;
  wire md_bit = mdio_sync_reg[1];
  wire sig_det = sig_sync_reg[1];

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  mdio_state_t md_state_reg;
  logic [5:0] pre_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [12:0] hdr_reg;
  logic [15:0] sh_reg;
  logic [15:0] addr_reg;
  logic mine_reg;
  logic [1:0] op_reg;
  logic [15:0] rdata;

  // header after the first start bit: st2, op, port, device
  wire [12:0] hdr_full = {hdr_reg[11:0], md_bit};
  // a frame is ours when start bit, port and device all match
  wire hdr_st_ok = (hdr_full[12] == 1'b0);
  wire hdr_port_ok = (hdr_full[9:5] == prt_s2_reg);
  wire hdr_dev_ok = (hdr_full[4:0] == DEV_PMA_PMD);
  wire hdr_mine = hdr_st_ok && hdr_port_ok && hdr_dev_ok;
  wire is_read = (op_reg == OP_READ) || (op_reg == OP_READ_INC);
  wire frame_end = mdc_rise && (md_state_reg == MD_DATA) && (bit_cnt_reg == 4'hF);
  wire wr_fire = frame_end && mine_reg && (op_reg == OP_WRITE);
  wire [15:0] wr_data = {sh_reg[14:0], md_bit};

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      md_state_reg <= MD_IDLE;
      pre_cnt_reg <= 6'h00;
      bit_cnt_reg <= 4'h0;
      hdr_reg <= 13'h0000;
      sh_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      mine_reg <= 1'b0;
      op_reg <= 2'h0;
      mdio_out <= 1'b1;
      mdio_oe_out <= 1'b0;
    end else if (mdc_rise) begin
      unique case (md_state_reg)
        MD_IDLE: begin
          // the count saturates, so a long idle still counts as preamble
          if (md_bit) begin
            if (pre_cnt_reg != 6'(PREAMBLE_BITS)) begin
              pre_cnt_reg <= pre_cnt_reg + 6'h01;
            end
          end else if (pre_cnt_reg == 6'(PREAMBLE_BITS)) begin
            md_state_reg <= MD_HEAD;
            bit_cnt_reg <= 4'h0;
          end else begin
            pre_cnt_reg <= 6'h00;
          end
        end
        MD_HEAD: begin
          hdr_reg <= hdr_full;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'hC) begin
            md_state_reg <= MD_TURN;
            bit_cnt_reg <= 4'h0;
            mine_reg <= hdr_mine;
            op_reg <= hdr_full[11:10];
          end
        end
        MD_TURN: begin
          bit_cnt_reg <= 4'h1;
          // first turnaround bit: take the wire and hold it low
          if (bit_cnt_reg == 4'h0) begin
            if (mine_reg && is_read) begin
              mdio_oe_out <= 1'b1;
              mdio_out <= 1'b0;
            end
          end else begin
            // second turnaround bit: present the msb of the answer
            md_state_reg <= MD_DATA;
            bit_cnt_reg <= 4'h0;
            sh_reg <= rdata;
            mdio_out <= rdata[15];
          end
        end
        MD_DATA: begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (is_read) begin
            sh_reg <= {sh_reg[14:0], 1'b0};
            mdio_out <= sh_reg[14];
          end else begin
            sh_reg <= wr_data;
          end
          if (bit_cnt_reg == 4'hF) begin
            // last data bit: hand the wire back to the pull-up
            md_state_reg <= MD_IDLE;
            pre_cnt_reg <= 6'h00;
            mdio_oe_out <= 1'b0;
            mdio_out <= 1'b1;
            if (mine_reg && op_reg == OP_ADDR) begin
              addr_reg <= wr_data;
            end else if (mine_reg && op_reg == OP_READ_INC) begin
              addr_reg <= addr_reg + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // control and enable registers
  // ----------------------------------------
  logic tx_off_reg;
  logic [15:0] rx_en_reg;
  logic [15:0] tx_en_reg;

  // writes land on the sixteenth data bit of a write frame
  wire wr_tx_off = wr_fire && (addr_reg == OFF_TX_OFF);
  wire wr_rx_en = wr_fire && (addr_reg == OFF_RX_ALARM_EN);
  wire wr_tx_en = wr_fire && (addr_reg == OFF_TX_ALARM_EN);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_off_reg <= 1'b0;
      rx_en_reg <= RX_EN_RESET;
      tx_en_reg <= TX_EN_RESET;
    end else begin
      if (wr_tx_off) begin
        tx_off_reg <= wr_data[0];
      end
      // reserved bits are masked on write, so they read zero
      // receive and transmit enables
      if (wr_rx_en) begin
        rx_en_reg <= wr_data & RX_EN_MASK;
      end
      if (wr_tx_en) begin
        tx_en_reg <= wr_data & TX_EN_MASK;
      end
    end
  end

  assign tx_off_out = tx_off_reg;

  // ----------------------------------------
  // nonvolatile command engine
  // ----------------------------------------
  nv_status_t nv_status_reg;
  logic [8:0] nv_cnt_reg;
  logic [6:0] nv_vendor_reg;
  logic nv_dir_reg;
  logic [1:0] nv_ext_reg;

  wire wr_nv_cmd = wr_fire && (addr_reg == OFF_NV_CMD);
  wire nv_busy = (nv_status_reg == NV_BUSY);
  wire [1:0] cmd_ext = wr_data[1:0];
  wire cmd_ok = (cmd_ext == EXT_ONE_BYTE) || (cmd_ext == EXT_ALL);
  wire [8:0] cmd_len = (cmd_ext == EXT_ALL) ? NV_ALL_CYCLES : NV_BYTE_CYCLES;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nv_status_reg <= NV_IDLE;
      nv_cnt_reg <= 9'h000;
      nv_vendor_reg <= 7'h00;
      nv_dir_reg <= 1'b0;
      nv_ext_reg <= 2'h0;
    end else begin
      // vendor bits always land; a write while busy leaves the command alone
      if (wr_nv_cmd) begin
        nv_vendor_reg <= wr_data[15:9];
      end
      if (wr_nv_cmd && !nv_busy) begin
        nv_dir_reg <= wr_data[CMD_DIR_BIT];
        nv_ext_reg <= cmd_ext;
        nv_cnt_reg <= cmd_len;
        nv_status_reg <= cmd_ok ? NV_BUSY : NV_FAIL;
      end else if (nv_busy) begin
        nv_cnt_reg <= nv_cnt_reg - 9'h001;
        if (nv_cnt_reg == 9'h001) begin
          nv_status_reg <= NV_DONE;
        end
      end
    end
  end

  // ----------------------------------------
  // customer writable image area
  // ----------------------------------------
  // plain storage: no command moves these bytes anywhere
  logic [7:0] cust_reg [CUST_BYTES];

  wire in_nv_page = (addr_reg[15:8] == NV_PAGE) && (addr_reg[7:0] != 8'h00);
  wire [7:0] img_idx = addr_reg[7:0];
  wire in_cust = (img_idx >= IMG_CUST_FIRST) && (img_idx <= IMG_CUST_LAST);
  wire [5:0] cust_idx = 6'(img_idx - IMG_CUST_FIRST);
  wire wr_cust = wr_fire && in_nv_page && in_cust;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < CUST_BYTES; i++) begin
        cust_reg[i] <= 8'h00;
      end
    end else if (wr_cust) begin
      cust_reg[cust_idx] <= wr_data[7:0];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // id bytes mirror
  wire [7:0] id_byte0 = PKG_ID[31:24];
  wire [7:0] id_byte1 = PKG_ID[23:16];
  wire [7:0] id_byte2 = PKG_ID[15:8];
  wire [7:0] id_byte3 = PKG_ID[7:0];
  wire [1:0] id_sel = 2'(img_idx - IMG_PKG_ID_FIRST);
  wire in_id = (img_idx >= IMG_PKG_ID_FIRST) && (img_idx <= IMG_PKG_ID_LAST);
  wire [7:0] id_byte = (id_sel == 2'h0) ? id_byte0 : (id_sel == 2'h1) ? id_byte1 :
    (id_sel == 2'h2) ? id_byte2 : id_byte3;
  wire [7:0] img_byte = in_id ? id_byte : in_cust ? cust_reg[cust_idx] :
    image_rom(img_idx);
  // bits 8:6 and 4 are reserved and read zero
  wire [15:0] nv_cmd_word = {nv_vendor_reg, 3'h0, nv_dir_reg, 1'b0,
    nv_status_reg, nv_ext_reg};

  // one hit per mapped offset; unmapped offsets read zero
  wire hit_tx_off = (addr_reg == OFF_TX_OFF);
  wire hit_sig_det = (addr_reg == OFF_SIG_DET);
  wire hit_ext_ability = (addr_reg == OFF_EXT_ABILITY);
  wire hit_id_high = (addr_reg == OFF_PKG_ID_HIGH);
  wire hit_id_low = (addr_reg == OFF_PKG_ID_LOW);
  wire hit_nv_cmd = (addr_reg == OFF_NV_CMD);
  wire hit_rx_en = (addr_reg == OFF_RX_ALARM_EN);
  wire hit_tx_en = (addr_reg == OFF_TX_ALARM_EN);

  // read words of the plain registers
  wire [15:0] tx_off_word = {15'h0000, tx_off_reg};
  wire [15:0] sig_det_word = {15'h0000, sig_det};
  wire [15:0] ext_ability_word = 16'h0000;
  wire [15:0] id_high_word = {id_byte0, id_byte1};
  wire [15:0] id_low_word = {id_byte2, id_byte3};

  // hits are one-hot, so an and-or tree selects the word
  wire [15:0] reg_word = ({16{hit_tx_off}} & tx_off_word) |
    ({16{hit_sig_det}} & sig_det_word) |
    ({16{hit_ext_ability}} & ext_ability_word) |
    ({16{hit_id_high}} & id_high_word) |
    ({16{hit_id_low}} & id_low_word) |
    ({16{hit_nv_cmd}} & nv_cmd_word) |
    ({16{hit_rx_en}} & rx_en_reg) |
    ({16{hit_tx_en}} & tx_en_reg);

  assign rdata = in_nv_page ? {8'h00, img_byte} : reg_word;

  // ----------------------------------------
  // alarm outputs
  // ----------------------------------------
  // status inputs share this clock, so they need no synchroniser
  wire rx_alarm = |(rx_alarm_status_in & rx_en_reg);
  wire tx_alarm = |(tx_alarm_status_in & tx_en_reg);
  wire link_status_alarm = sig_det & pcs_block_lock_in & phy_xs_lane_align_in;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_alarm_out <= 1'b0;
      tx_alarm_out <= 1'b0;
      link_status_alarm_out <= 1'b0;
    end else begin
      rx_alarm_out <= rx_alarm;
      tx_alarm_out <= tx_alarm;
      link_status_alarm_out <= link_status_alarm;
    end
  end

endmodule

// ### bench/pmd_mgmt_nvr_alarm_regs_chk.sv
`timescale 1ns/1ps
module pmd_mgmt_nvr_alarm_regs_chk (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // management and optics
  input wire logic mdio_oe_out,
  input wire logic signal_detect_in,
  input wire logic tx_off_out,
  // alarms
  input wire logic [15:0] rx_alarm_status_in,
  input wire logic [15:0] tx_alarm_status_in,
  input wire logic pcs_block_lock_in,
  input wire logic phy_xs_lane_align_in,
  input wire logic rx_alarm_out,
  input wire logic tx_alarm_out,
  input wire logic link_status_alarm_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  rx_mask_a: assert property (
    (rx_alarm_status_in & 16'h0039) == 16'h0000 |=> !rx_alarm_out)
    else $error("rx alarm with no enabled status");
  rx_rise_a: assert property (
    $rose(rx_alarm_out) |-> $past(rx_alarm_status_in) != 16'h0000)
    else $error("rx alarm rose with idle status");
  tx_mask_a: assert property (
    (tx_alarm_status_in & 16'h02D9) == 16'h0000 |=> !tx_alarm_out)
    else $error("tx alarm with no enabled status");
  tx_rise_a: assert property (
    $rose(tx_alarm_out) |-> $past(tx_alarm_status_in) != 16'h0000)
    else $error("tx alarm rose with idle status");
  link_on_a: assert property (
    (signal_detect_in && pcs_block_lock_in && phy_xs_lane_align_in) [*4] |=> link_status_alarm_out)
    else $error("link alarm low with all sources true");
  link_off_a: assert property (
    !(pcs_block_lock_in && phy_xs_lane_align_in) |=> !link_status_alarm_out)
    else $error("link alarm high without lock and alignment");
  detect_off_a: assert property (
    !signal_detect_in [*4] |=> !link_status_alarm_out)
    else $error("link alarm high without signal");
  tx_off_a: assert property (
    $changed(tx_off_out) |-> !mdio_oe_out)
    else $error("transmit off changed during a read answer");
  rst_quiet_a: assert property (
    $fell(sys_rst_in) |-> !tx_off_out && !mdio_oe_out)
    else $error("transmitter or data driver active after reset");
endmodule

bind pmd_mgmt_nvr_alarm_regs pmd_mgmt_nvr_alarm_regs_chk chk_u (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .mdio_oe_out(mdio_oe_out),
  .signal_detect_in(signal_detect_in), .tx_off_out(tx_off_out),
  .rx_alarm_status_in(rx_alarm_status_in), .tx_alarm_status_in(tx_alarm_status_in),
  .pcs_block_lock_in(pcs_block_lock_in), .phy_xs_lane_align_in(phy_xs_lane_align_in),
  .rx_alarm_out(rx_alarm_out), .tx_alarm_out(tx_alarm_out),
  .link_status_alarm_out(link_status_alarm_out));

// ### bench/mdio_host.sv
`timescale 1ns/1ps
module mdio_host (
  // clock
  input wire logic clk_sys_in,
  // management pins
  output logic mdc_out,
  output logic mdio_drv_out,
  output logic mdio_oe_out,
  input wire logic mdio_wire_in
);
  import pmd_mgmt_pkg::*;
  initial begin
    mdc_out = 1'b0;
    mdio_drv_out = 1'b1;
    mdio_oe_out = 1'b0;
  end

  // data changes with mdc low, sampled just before the rise
  task automatic send_bit(input logic b, input logic drive, output logic s);
    @(posedge clk_sys_in);
    mdc_out <= 1'b0;
    mdio_drv_out <= b;
    mdio_oe_out <= drive;
    repeat (8) @(posedge clk_sys_in);
    s = mdio_wire_in;
    mdc_out <= 1'b1;
    repeat (7) @(posedge clk_sys_in);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] head;
    logic s;
    head = {2'b00, op, prt, DEV_PMA_PMD};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) send_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) send_bit(head[i], 1'b1, s);
    send_bit(1'b1, !op[1], s);
    send_bit(1'b0, !op[1], s);
    for (int i = 15; i >= 0; i--) begin
      send_bit(wd[i], !op[1], s);
      rd[i] = s;
    end
    @(posedge clk_sys_in);
    mdio_oe_out <= 1'b0;
  endtask
endmodule

// ### bench/test_pmd_mgmt_nvr_alarm_regs.sv
`timescale 1ns/1ps
module test_pmd_mgmt_nvr_alarm_regs;
  import pmd_mgmt_pkg::*;
  // arbitrary identity value
  localparam logic [31:0] ID = 32'hA5C3_1E70;
  localparam logic [4:0] PRT = 5'h03;
  logic clk_sys_in, sys_rst_in, mdc, host_drv, host_oe, mdio_wire, mdio_out, mdio_oe;
  logic signal_detect_in, tx_off, pcs_lock, lane_align, rx_alarm, tx_alarm, link_alarm;
  logic [15:0] rx_status, tx_status, cur_addr;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  // pull-up holds the wire high when nobody drives
  assign mdio_wire = mdio_oe ? mdio_out : (host_oe ? host_drv : 1'b1);

  mdio_host host_u (.clk_sys_in(clk_sys_in), .mdc_out(mdc), .mdio_drv_out(host_drv),
    .mdio_oe_out(host_oe), .mdio_wire_in(mdio_wire));
  pmd_mgmt_nvr_alarm_regs #(.PKG_ID(ID)) dut_u (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .mdc_in(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe), .port_addr_in(PRT), .signal_detect_in(signal_detect_in),
    .tx_off_out(tx_off), .rx_alarm_status_in(rx_status), .tx_alarm_status_in(tx_status),
    .pcs_block_lock_in(pcs_lock), .phy_xs_lane_align_in(lane_align),
    .rx_alarm_out(rx_alarm), .tx_alarm_out(tx_alarm), .link_status_alarm_out(link_alarm));

  // ----
  // shared tasks
  // ----
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input logic [15:0] a, input logic w, input logic [15:0] d,
                     output logic [15:0] rd);
    if (a !== cur_addr) host_u.frame(OP_ADDR, PRT, a, rd);
    cur_addr = a;
    host_u.frame(w ? OP_WRITE : OP_READ, PRT, d, rd);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] v;
    acc(a, 1'b1, d, v);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] v;
    acc(a, 1'b0, 16'h0000, v);
    check(what, v, exp);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    rd_chk("tx off", OFF_TX_OFF, 16'h0000);
    rd_chk("detect", OFF_SIG_DET, 16'h0001);
    rd_chk("ability", OFF_EXT_ABILITY, 16'h0000);
    rd_chk("rx en", OFF_RX_ALARM_EN, 16'h0039);
    rd_chk("tx en", OFF_TX_ALARM_EN, 16'h02D9);
    rd_chk("nv cmd", OFF_NV_CMD, 16'h0000);
    rd_chk("unmapped", 16'h0100, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_tx_off;
    wr(OFF_TX_OFF, 16'hFFE1);
    check("tx pin on", {15'h0, tx_off}, 16'h0001);
    rd_chk("tx off rd", OFF_TX_OFF, 16'h0001);
    wr(OFF_TX_OFF, 16'h0000);
    check("tx pin off", {15'h0, tx_off}, 16'h0000);
    $display("test tx off done");
  endtask

  task automatic t_detect;
    signal_detect_in <= 1'b0;
    wr(OFF_SIG_DET, 16'hFFFF);
    rd_chk("detect low", OFF_SIG_DET, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      {signal_detect_in, pcs_lock, lane_align} <= 3'(k);
      repeat (6) @(posedge clk_sys_in);
      check("link alarm", {15'h0, link_alarm}, {15'h0, k == 7});
    end
    $display("test detect done");
  endtask

  task automatic t_pkg_id;
    logic [15:0] v;
    rd_chk("id high", OFF_PKG_ID_HIGH, ID[31:16]);
    rd_chk("id low", OFF_PKG_ID_LOW, ID[15:0]);
    for (int i = 0; i < 4; i++) begin
      rd_chk("id byte", 16'h8032 + 16'(i), {8'h00, ID[31-8*i -: 8]});
    end
    // read with post-increment steps to the next id byte
    host_u.frame(OP_ADDR, PRT, 16'h8032, v);
    host_u.frame(OP_READ_INC, PRT, 16'h0000, v);
    check("id inc first", v, {8'h00, ID[31:24]});
    host_u.frame(OP_READ, PRT, 16'h0000, v);
    check("id inc next", v, {8'h00, ID[23:16]});
    cur_addr = 16'h8033;
    $display("test package id done");
  endtask

  task automatic t_image;
    logic [15:0] adr [7] = '{16'h8008, 16'h800A, 16'h800C, 16'h800D, 16'h800E, 16'h800F,
                             16'h807A};
    logic [7:0] val [7] = '{8'h01, 8'h01, 8'h0B, 8'h77, 8'hA7, 8'h01, 8'hC1};
    for (int i = 0; i < 7; i++) begin
      rd_chk("image", adr[i], {8'h00, val[i]});
    end
    $display("test image done");
  endtask

  task automatic t_alarm;
    logic [15:0] v;
    for (int b = 0; b < 16; b++) begin
      rx_status <= 16'h0001 << b;
      tx_status <= 16'h0001 << b;
      repeat (3) @(posedge clk_sys_in);
      check("rx bit", {15'h0, rx_alarm}, {15'h0, 1'(16'h0039 >> b)});
      check("tx bit", {15'h0, tx_alarm}, {15'h0, 1'(16'h02D9 >> b)});
    end
    rx_status <= 16'hFFFF;
    wr(OFF_RX_ALARM_EN, 16'h0000);
    check("rx masked", {15'h0, rx_alarm}, 16'h0000);
    host_u.frame(OP_WRITE, PRT + 5'h01, 16'hFFFF, v);
    rd_chk("rx en kept", OFF_RX_ALARM_EN, 16'h0000);
    wr(OFF_TX_ALARM_EN, 16'hFFFF);
    rd_chk("tx en rw", OFF_TX_ALARM_EN, 16'h02D9);
    $display("test alarm done");
  endtask

  task automatic t_nv;
    logic [1:0] code;
    for (int c = 0; c < 4; c++) begin
      code = 2'(c);
      wr(OFF_NV_CMD, {10'h000, 1'b1, 3'b000, code});
      rd_chk("nv", OFF_NV_CMD, {10'h000, 2'b10, code[1] ? 2'b01 : 2'b11, code});
    end
    $display("test nonvolatile command done");
  endtask

  // ----
  // clock, watchdog, sequence
  // ----
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 80000) begin
      check("run time", 16'h0000, 16'h0001);
      test_done();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    signal_detect_in = 1'b1;
    pcs_lock = 1'b1;
    lane_align = 1'b1;
    rx_status = 16'h0000;
    tx_status = 16'h0000;
    cur_addr = 16'hFFFF;
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_tx_off();
    t_detect();
    t_pkg_id();
    t_image();
    t_alarm();
    t_nv();
    test_done();
  end
endmodule
